// ---- inc/strap_pins_pkg.sv ----
package strap_pins_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] FEATURE_CFG_OFS = 8'h00;
    localparam logic [7:0] CHARGE_SUPPORT_OFS = 8'h04;
    localparam logic [7:0] STRAP_STATUS_OFS = 8'h08;

    // Field positions
    localparam int STATUS_OUTPUT_ENABLE_POS = 0;
    localparam int AUTO_MODE_DISABLE_POS = 0;
    localparam int STS_GANG_POS = 0;
    localparam int STS_AUTO_N_POS = 1;
    localparam int STS_IFACE_N_POS = 2;
    localparam int STS_PWR_N_POS = 3;
    localparam int STS_VALID_POS = 4;

    // Values after reset
    localparam logic STATUS_OUTPUT_ENABLE_RST = 1'b0;
    localparam logic AUTO_MODE_DISABLE_RST = 1'b1;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // Edges after reset release before the synchronised straps are sampled
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;

    typedef struct packed {
        logic gang;
        logic auto_n;
        logic iface_n;
        logic pwr_n;
    } strap_s;

    localparam strap_s STRAP_RST = 4'h0;

endpackage : strap_pins_pkg

// ---- logic/hub_strap_status_pins.sv ----
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
module hub_strap_status_pins (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic gang_addr2_hs_conn_pin_in,
    output logic gang_addr2_hs_conn_pin_out,
    output logic gang_addr2_hs_conn_pin_oe_n_out,
    input wire logic auto_charge_hs_susp_pin_in,
    output logic auto_charge_hs_susp_pin_out,
    output logic auto_charge_hs_susp_pin_oe_n_out,
    input wire logic interface_select_strap_n_in,
    input wire logic power_switching_strap_n_in,
    input wire logic hs_upstream_connected_in,
    input wire logic hs_upstream_suspended_in,
    input wire logic [strap_pins_pkg::ADDR_W-1:0] addr_in,
    input wire logic [strap_pins_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [strap_pins_pkg::DATA_W-1:0] rdata_out,
    output logic straps_valid_out,
    output logic power_switching_en_out,
    output logic ganged_power_out,
    output logic smbus_mode_out,
    output logic smbus_addr_bit2_out,
    output logic auto_charge_mode_out,
    output logic cdp_port1_allowed_out
);

    // Pin synchronisers
    strap_pins_pkg::strap_s sync1_ff;
    strap_pins_pkg::strap_s sync2_ff;
    strap_pins_pkg::strap_s pin_now;

    assign pin_now = '{gang: gang_addr2_hs_conn_pin_in,
                       auto_n: auto_charge_hs_susp_pin_in,
                       iface_n: interface_select_strap_n_in,
                       pwr_n: power_switching_strap_n_in};

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_ff <= strap_pins_pkg::STRAP_RST;
            sync2_ff <= strap_pins_pkg::STRAP_RST;
        end else begin
            sync1_ff <= pin_now;
            sync2_ff <= sync1_ff;
        end
    end

    // Strap capture after release
    logic [1:0] settle_ff;
    logic [1:0] nxt_settle;
    logic valid_ff;
    logic nxt_valid;
    strap_pins_pkg::strap_s strap_ff;
    strap_pins_pkg::strap_s nxt_strap;
    logic capture;

    always_comb begin
        nxt_settle = settle_ff;
        nxt_valid = valid_ff;
        nxt_strap = strap_ff;
        capture = 1'b0;
        if (!valid_ff) begin
            if (settle_ff == strap_pins_pkg::SETTLE_CYCLES) begin
                capture = 1'b1;
                nxt_valid = 1'b1;
                nxt_strap = sync2_ff;
            end else begin
                nxt_settle = settle_ff + 2'h1;
            end
        end
    end

    // Held until next reset
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            settle_ff <= 2'h0;
            valid_ff <= 1'b0;
            strap_ff <= strap_pins_pkg::STRAP_RST;
        end else begin
            settle_ff <= nxt_settle;
            valid_ff <= nxt_valid;
            strap_ff <= nxt_strap;
        end
    end

    // Register file
    logic sts_out_en_ff;
    logic nxt_sts_out_en;
    logic auto_dis_ff;
    logic nxt_auto_dis;
    logic [strap_pins_pkg::DATA_W-1:0] rdata_ff;
    logic [strap_pins_pkg::DATA_W-1:0] nxt_rdata;

    always_comb begin
        nxt_sts_out_en = sts_out_en_ff;
        nxt_auto_dis = auto_dis_ff;
        if (wr_in) begin
            if (addr_in == strap_pins_pkg::FEATURE_CFG_OFS) begin
                nxt_sts_out_en = wdata_in[strap_pins_pkg::STATUS_OUTPUT_ENABLE_POS];
            end
            if (addr_in == strap_pins_pkg::CHARGE_SUPPORT_OFS) begin
                nxt_auto_dis = wdata_in[strap_pins_pkg::AUTO_MODE_DISABLE_POS];
            end
        end
        // Strap load beats a write in the same cycle
        if (capture) begin
            nxt_auto_dis = sync2_ff.auto_n;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sts_out_en_ff <= strap_pins_pkg::STATUS_OUTPUT_ENABLE_RST;
            auto_dis_ff <= strap_pins_pkg::AUTO_MODE_DISABLE_RST;
        end else begin
            sts_out_en_ff <= nxt_sts_out_en;
            auto_dis_ff <= nxt_auto_dis;
        end
    end

    // Read data stands one cycle, then zero
    always_comb begin
        nxt_rdata = strap_pins_pkg::RDATA_RST;
        if (rd_in) begin
            case (addr_in)
                strap_pins_pkg::FEATURE_CFG_OFS: begin
                    nxt_rdata[strap_pins_pkg::STATUS_OUTPUT_ENABLE_POS] = sts_out_en_ff;
                end
                strap_pins_pkg::CHARGE_SUPPORT_OFS: begin
                    nxt_rdata[strap_pins_pkg::AUTO_MODE_DISABLE_POS] = auto_dis_ff;
                end
                strap_pins_pkg::STRAP_STATUS_OFS: begin
                    nxt_rdata[strap_pins_pkg::STS_GANG_POS] = strap_ff.gang;
                    nxt_rdata[strap_pins_pkg::STS_AUTO_N_POS] = strap_ff.auto_n;
                    nxt_rdata[strap_pins_pkg::STS_IFACE_N_POS] = strap_ff.iface_n;
                    nxt_rdata[strap_pins_pkg::STS_PWR_N_POS] = strap_ff.pwr_n;
                    nxt_rdata[strap_pins_pkg::STS_VALID_POS] = valid_ff;
                end
                default: begin
                    nxt_rdata = strap_pins_pkg::RDATA_RST;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_ff <= strap_pins_pkg::RDATA_RST;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Gang pin status drive
    logic gang_pin_ff;
    logic nxt_gang_pin;
    logic gang_oe_n_ff;
    logic nxt_gang_oe_n;
    logic drive_status;

    always_comb begin
        drive_status = valid_ff && sts_out_en_ff;
        nxt_gang_oe_n = !drive_status;
        nxt_gang_pin = drive_status && hs_upstream_connected_in;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gang_pin_ff <= 1'b0;
            gang_oe_n_ff <= 1'b1;
        end else begin
            gang_pin_ff <= nxt_gang_pin;
            gang_oe_n_ff <= nxt_gang_oe_n;
        end
    end

    // Charge pin status drive
    logic auto_pin_ff;
    logic nxt_auto_pin;
    logic auto_oe_n_ff;
    logic nxt_auto_oe_n;

    always_comb begin
        nxt_auto_oe_n = !drive_status;
        nxt_auto_pin = drive_status && hs_upstream_suspended_in;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            auto_pin_ff <= 1'b0;
            auto_oe_n_ff <= 1'b1;
        end else begin
            auto_pin_ff <= nxt_auto_pin;
            auto_oe_n_ff <= nxt_auto_oe_n;
        end
    end

    // Power control mode
    logic pwr_en_ff;
    logic nxt_pwr_en;
    logic ganged_ff;
    logic nxt_ganged;

    always_comb begin
        nxt_pwr_en = valid_ff && !strap_ff.pwr_n;
        nxt_ganged = nxt_pwr_en && strap_ff.gang;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pwr_en_ff <= 1'b0;
            ganged_ff <= 1'b0;
        end else begin
            pwr_en_ff <= nxt_pwr_en;
            ganged_ff <= nxt_ganged;
        end
    end

    // Interface mode and address bit
    logic smbus_ff;
    logic nxt_smbus;
    logic addr2_ff;
    logic nxt_addr2;

    always_comb begin
        nxt_smbus = valid_ff && !strap_ff.iface_n;
        nxt_addr2 = nxt_smbus && strap_ff.gang;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            smbus_ff <= 1'b0;
            addr2_ff <= 1'b0;
        end else begin
            smbus_ff <= nxt_smbus;
            addr2_ff <= nxt_addr2;
        end
    end

    // Charge mode
    logic auto_mode_ff;
    logic nxt_auto_mode;
    logic cdp1_ff;
    logic nxt_cdp1;

    always_comb begin
        nxt_auto_mode = valid_ff && !auto_dis_ff;
        nxt_cdp1 = valid_ff && !nxt_auto_mode;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            auto_mode_ff <= 1'b0;
            cdp1_ff <= 1'b0;
        end else begin
            auto_mode_ff <= nxt_auto_mode;
            cdp1_ff <= nxt_cdp1;
        end
    end

    // Valid flag aligned with the registered mode outputs
    logic valid_out_ff;
    logic nxt_valid_out;

    always_comb begin
        nxt_valid_out = valid_ff;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            valid_out_ff <= 1'b0;
        end else begin
            valid_out_ff <= nxt_valid_out;
        end
    end

    assign gang_addr2_hs_conn_pin_out = gang_pin_ff;
    assign gang_addr2_hs_conn_pin_oe_n_out = gang_oe_n_ff;
    assign auto_charge_hs_susp_pin_out = auto_pin_ff;
    assign auto_charge_hs_susp_pin_oe_n_out = auto_oe_n_ff;
    assign rdata_out = rdata_ff;
    assign straps_valid_out = valid_out_ff;
    assign power_switching_en_out = pwr_en_ff;
    assign ganged_power_out = ganged_ff;
    assign smbus_mode_out = smbus_ff;
    assign smbus_addr_bit2_out = addr2_ff;
    assign auto_charge_mode_out = auto_mode_ff;
    assign cdp_port1_allowed_out = cdp1_ff;

endmodule : hub_strap_status_pins

// ---- testbench/hub_strap_status_pins_assertions.sv ----
`timescale 1ns/1ps
module hub_strap_checker (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic gang_addr2_hs_conn_pin_out,
    input wire logic gang_addr2_hs_conn_pin_oe_n_out,
    input wire logic auto_charge_hs_susp_pin_out,
    input wire logic auto_charge_hs_susp_pin_oe_n_out,
    input wire logic hs_upstream_connected_in,
    input wire logic hs_upstream_suspended_in,
    input wire logic straps_valid_out,
    input wire logic power_switching_en_out,
    input wire logic ganged_power_out,
    input wire logic smbus_mode_out,
    input wire logic smbus_addr_bit2_out,
    input wire logic auto_charge_mode_out,
    input wire logic cdp_port1_allowed_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_capture;
        !straps_valid_out [*4] ##1 straps_valid_out;
    endsequence
    a_capture_time: assert property (!$past(nrst_in) |-> s_capture)
        else $error("straps not captured on time");
    a_conn_follow: assert property (!gang_addr2_hs_conn_pin_oe_n_out |->
        gang_addr2_hs_conn_pin_out == $past(hs_upstream_connected_in))
        else $error("gang pin not showing connection");
    a_susp_follow: assert property (!auto_charge_hs_susp_pin_oe_n_out |->
        auto_charge_hs_susp_pin_out == $past(hs_upstream_suspended_in))
        else $error("charge pin not showing suspend");
    a_drive_valid: assert property (!(gang_addr2_hs_conn_pin_oe_n_out &&
        auto_charge_hs_susp_pin_oe_n_out) |-> straps_valid_out)
        else $error("pin driven before capture");
    a_straps_hold: assert property (straps_valid_out && $past(straps_valid_out) |->
        $stable({power_switching_en_out, ganged_power_out, smbus_mode_out,
        smbus_addr_bit2_out}))
        else $error("captured mode changed");
    a_gang_pwr: assert property (ganged_power_out |-> power_switching_en_out)
        else $error("ganged without switching");
    a_addr2_smbus: assert property (smbus_addr_bit2_out |-> smbus_mode_out)
        else $error("address bit outside smbus mode");
    a_cdp_auto: assert property (straps_valid_out |->
        cdp_port1_allowed_out != auto_charge_mode_out)
        else $error("cdp offered in auto mode");
    a_pin_quiet: assert property (gang_addr2_hs_conn_pin_oe_n_out |->
        !gang_addr2_hs_conn_pin_out)
        else $error("undriven pin value not zero");
endmodule : hub_strap_checker
bind hub_strap_status_pins hub_strap_checker u_chk (.*);

// ---- testbench/strap_board_model.sv ----
`timescale 1ns/1ps
module strap_board_model (
    input wire logic charge_en_in,
    input wire strap_pins_pkg::strap_s strap_in,
    input wire logic gang_in,
    input wire logic gang_oe_n_in,
    input wire logic auto_in,
    input wire logic auto_oe_n_in,
    output logic gang_out,
    output logic auto_out
);
    logic gang_strap;
    // Charging boards fit the per-port strap
    assign gang_strap = charge_en_in ? 1'b0 : strap_in.gang;
    assign gang_out = gang_oe_n_in ? gang_strap : gang_in;
    assign auto_out = auto_oe_n_in ? strap_in.auto_n : auto_in;
endmodule : strap_board_model

// ---- testbench/tb_hub_strap_status_pins.sv ----
`timescale 1ns/1ps
module tb_hub_strap_status_pins;
    logic clk_in = 1'b0, nrst_in = 1'b0, chg = 1'b0, conn = 1'b0, susp = 1'b0;
    logic wr = 1'b0, rd = 1'b0, g, pc, ps, gw, aw, go, goe, ao, aoe;
    logic valid, pen, gpw, smb, a2, amode, cdp;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdata, rv, r, seed = 32'h0000_dfb2;
    strap_pins_pkg::strap_s st = 4'h0, cap;
    int fail_count = 0, checks = 0, n;
    always #5 clk_in = ~clk_in;
    strap_board_model board (.charge_en_in(chg), .strap_in(st), .gang_in(go),
        .gang_oe_n_in(goe), .auto_in(ao), .auto_oe_n_in(aoe), .gang_out(gw), .auto_out(aw));
    hub_strap_status_pins DUT (.clk_in(clk_in), .nrst_in(nrst_in),
        .gang_addr2_hs_conn_pin_in(gw), .gang_addr2_hs_conn_pin_out(go),
        .gang_addr2_hs_conn_pin_oe_n_out(goe), .auto_charge_hs_susp_pin_in(aw),
        .auto_charge_hs_susp_pin_out(ao), .auto_charge_hs_susp_pin_oe_n_out(aoe),
        .interface_select_strap_n_in(st.iface_n), .power_switching_strap_n_in(st.pwr_n),
        .hs_upstream_connected_in(conn), .hs_upstream_suspended_in(susp), .addr_in(addr),
        .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .straps_valid_out(valid),
        .power_switching_en_out(pen), .ganged_power_out(gpw), .smbus_mode_out(smb),
        .smbus_addr_bit2_out(a2), .auto_charge_mode_out(amode), .cdp_port1_allowed_out(cdp));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t bit %b want %b", $time, got, exp);
        end
    endtask : chk_bit
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t word %h want %h", $time, got, exp);
        end
    endtask : chk_word
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [7:0] a);
        @(posedge clk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask : rd_reg
    task test_done;
        $display("Counts: %0d checks, %0d failures", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    initial begin
        for (int t = 0; t < 12; t++) begin
            r = rnd();
            @(posedge clk_in);
            nrst_in <= 1'b0;
            st <= (t < 2) ? {4{t[0]}} : r[3:0];
            chg <= r[4];
            repeat (6) @(posedge clk_in);
            #1 chk_bit(goe & aoe, 1'b1);
            @(posedge clk_in);
            nrst_in <= 1'b1;
            n = 0;
            while (valid !== 1'b1 && n < 20) begin
                @(posedge clk_in);
                #1 n++;
            end
            if (n == 20) begin
                fail_count++;
                $display("CHECK FAILED t=%0t capture timeout", $time);
                test_done();
            end
            cap = st;
            g = chg ? 1'b0 : st.gang;
            chk_bit(pen, !cap.pwr_n);
            chk_bit(gpw, !cap.pwr_n & g);
            chk_bit(smb, !cap.iface_n);
            chk_bit(a2, !cap.iface_n & g);
            chk_bit(amode, !cap.auto_n);
            chk_bit(cdp, cap.auto_n);
            @(posedge clk_in);
            st <= ~st;
            rd_reg(strap_pins_pkg::STRAP_STATUS_OFS);
            chk_word(rv, {27'h0, 1'b1, cap.pwr_n, cap.iface_n, cap.auto_n, g});
            rd_reg(strap_pins_pkg::CHARGE_SUPPORT_OFS);
            chk_word(rv, {31'h0, cap.auto_n});
            rd_reg(8'h0c);
            chk_word(rv, 32'h0000_0000);
            chk_bit(goe, 1'b1);
            pc = conn;
            ps = susp;
            wr_reg(strap_pins_pkg::FEATURE_CFG_OFS, 32'h0000_0001);
            repeat (8) begin
                @(posedge clk_in);
                r = rnd();
                conn <= r[0];
                susp <= r[1];
                #1 chk_bit(gw, pc);
                chk_bit(aw, ps);
                pc = r[0];
                ps = r[1];
            end
            wr_reg(strap_pins_pkg::CHARGE_SUPPORT_OFS, 32'h0000_0000);
            repeat (2) @(posedge clk_in);
            #1 chk_bit(amode, 1'b1);
            chk_bit(cdp, 1'b0);
            $display("test %0d done", t);
        end
        test_done();
    end
endmodule : tb_hub_strap_status_pins
